//--- tcpwm_pkg.sv
// package of the three channel pwm timer: offsets, field layouts, resets
// assumes a 32-bit axi4-lite master and one 25 MHz clock
`default_nettype none

package tcpwm_pkg;

	// ************************************************************
	// bus geometry
	// ************************************************************
	localparam int AXI_AW = 8;                   // byte address width
	localparam int AXI_DW = 32;                  // data width

	// ************************************************************
	// register byte offsets
	// ************************************************************
	localparam logic [7:0] OFS_CTRL    = 8'h00;  // run, clear, source
	localparam logic [7:0] OFS_OUTCFG  = 8'h04;  // polarity, initial level
	localparam logic [7:0] OFS_PERIOD  = 8'h08;  // period_compare_reg
	localparam logic [7:0] OFS_CHB     = 8'h0c;  // change_point_b_reg
	localparam logic [7:0] OFS_CHC     = 8'h10;  // change_point_c_reg
	localparam logic [7:0] OFS_CHD     = 8'h14;  // change_point_d_reg
	localparam logic [7:0] OFS_COUNT   = 8'h18;  // channel_counter
	localparam logic [7:0] OFS_STATUS  = 8'h1c;  // sticky events, w1c
	localparam logic [7:0] OFS_MASK    = 8'h20;  // interrupt enables

	// ************************************************************
	// field layouts
	// ************************************************************
	// control word, bit 0 is run
	typedef struct packed {
		logic       adTrigEn;                    // bit 5
		logic       cutoffEn;                    // bit 4
		logic [1:0] srcSel;                      // bits 3:2
		logic       clearOnPeriod;               // bit 1
		logic       run;                         // bit 0
	} tcpwm_ctrl_t;

	// output configuration, index 0 is B, 1 is C, 2 is D
	typedef struct packed {
		logic [2:0] initLevel;                   // bits 5:3
		logic [2:0] activeHigh;                  // bits 2:0
	} tcpwm_outcfg_t;

	// event bits, same layout in status and mask
	typedef struct packed {
		logic chdHit;                            // bit 3
		logic chcHit;                            // bit 2
		logic chbHit;                            // bit 1
		logic periodHit;                         // bit 0
	} tcpwm_evt_t;

	localparam int CTRL_W   = 6;
	localparam int OUTCFG_W = 6;
	localparam int EVT_W    = 4;

	// count source codes: undivided, /2, /4, /8
	localparam logic [1:0] SRC_DIV1 = 2'h0;
	localparam logic [1:0] SRC_DIV2 = 2'h1;
	localparam logic [1:0] SRC_DIV4 = 2'h2;
	localparam logic [1:0] SRC_DIV8 = 2'h3;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [5:0]  RST_CTRL    = 6'h02;  // stopped, clear on period
	localparam logic [5:0]  RST_OUTCFG  = 6'h07;  // active high, start low
	localparam logic [15:0] RST_PERIOD  = 16'hffff;
	localparam logic [15:0] RST_CHANGE  = 16'hffff;
	localparam logic [3:0]  RST_EVT     = 4'h0;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// merge a bus write into an old word, byte by byte
	function automatic logic [31:0] applyStrb(
		input logic [31:0] oldVal,
		input logic [31:0] newVal,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = oldVal;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[8*i +: 8] = newVal[8*i +: 8];
		end
		return res;
	endfunction

endpackage : tcpwm_pkg

`default_nettype wire

//--- tcpwm_chan.sv
// one pwm output channel: compare, set active, reset inactive
// assumes count and tick come from the shared channel counter
`default_nettype none

module tcpwm_chan #(
	parameter int COUNT_W = 16
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               reset_n,
	// shared counter state
	input  wire logic               run,
	input  wire logic               tick,
	input  wire logic [COUNT_W-1:0] count,
	input  wire logic               periodHit,
	input  wire logic               forceOff,
	// configuration
	input  wire logic [COUNT_W-1:0] changePoint,
	input  wire logic               activeHigh,
	input  wire logic               initLevel,
	// results
	output logic                    hit,
	output logic                    level_q
);

	// ************************************************************
	// compare
	// ************************************************************
	// a match only counts on a count source edge
	assign hit = tick && (count == changePoint);

	// ************************************************************
	// output level
	// ************************************************************
	// period wins over a change point sitting at the same count
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			level_q <= 1'b0;
		else if (!run)
			level_q <= initLevel;
		else if (forceOff)
			level_q <= ~activeHigh;
		else if (periodHit)
			level_q <= ~activeHigh;
		else if (hit)
			level_q <= activeHigh;
	end

endmodule // tcpwm_chan

`default_nettype wire

//--- tcpwm_timer.sv
// three channel pwm timer with axi4-lite register slave
// assumes inputs synchronous to clk; cutoffIn is a clean level
`default_nettype none

module tcpwm_timer #(
	parameter int COUNT_W = 16                   // counter and compare width
) (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        reset_n,
	// axi4-lite write address
	input  wire logic [tcpwm_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  wire logic [2:0]                  s_axi_awprot,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// axi4-lite read address
	input  wire logic [tcpwm_pkg::AXI_AW-1:0] s_axi_araddr,
	input  wire logic [2:0]                  s_axi_arprot,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// forced cutoff request
	input  wire logic                        cutoffIn,
	// pwm pins, interrupt and converter trigger
	output logic                             pwm_out_b,
	output logic                             pwm_out_c,
	output logic                             pwm_out_d,
	output logic                             irq,
	output logic                             adTrigger_q
);

	// ************************************************************
	// declarations
	// ************************************************************
	tcpwm_pkg::tcpwm_ctrl_t   ctrl_q;            // control word
	tcpwm_pkg::tcpwm_outcfg_t outCfg_q;          // polarity and init level
	tcpwm_pkg::tcpwm_evt_t    status_q;          // sticky events
	tcpwm_pkg::tcpwm_evt_t    status_d;
	tcpwm_pkg::tcpwm_evt_t    mask_q;            // interrupt enables
	tcpwm_pkg::tcpwm_evt_t    events;            // this cycle's events

	logic [COUNT_W-1:0] period_compare_reg_q;   // period compare
	logic [COUNT_W-1:0] change_point_b_reg_q;   // change point b
	logic [COUNT_W-1:0] change_point_c_reg_q;   // change point c
	logic [COUNT_W-1:0] change_point_d_reg_q;   // change point d
	logic [COUNT_W-1:0] channel_counter_q;      // the channel counter

	logic [2:0]  prescale_q;                     // count source divider
	logic [2:0]  divMask;                        // divider terminal mask
	logic        tick;                           // one count source edge
	logic        periodHit;                      // counter reached period
	logic        forceOff;                       // cutoff active
	logic [2:0]  chanHit;                        // b, c, d matches
	logic [2:0]  chanLevel;                      // b, c, d pin levels

	// write and read channel holding state
	logic        awHeld_q;                       // address taken
	logic [7:0]  awAddr_q;
	logic        wHeld_q;                        // data taken
	logic [31:0] wData_q;
	logic [3:0]  wStrb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [1:0]  rresp_q;
	logic [31:0] rdata_q;

	logic        doWrite;                        // both halves present
	logic        wrHit;                          // address is mapped
	logic [31:0] rdMux;                          // read data before flop
	logic        rdHit;                          // read address is mapped

	// ************************************************************
	// axi handshakes
	// ************************************************************
	// each half is taken alone; a new write waits for the response
	assign s_axi_awready = !awHeld_q && !bvalid_q;
	assign s_axi_wready  = !wHeld_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign doWrite       = awHeld_q && wHeld_q && !bvalid_q;

	// address and data holding, response generation
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			awHeld_q <= 1'b0;
			awAddr_q <= 8'h00;
			wHeld_q  <= 1'b0;
			wData_q  <= 32'h0000_0000;
			wStrb_q  <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q  <= tcpwm_pkg::RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (doWrite)
			begin
				// unmapped writes are dropped and flagged
				awHeld_q <= 1'b0;
				wHeld_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= wrHit ? tcpwm_pkg::RESP_OKAY
					: tcpwm_pkg::RESP_SLVERR;
			end
			else if (bvalid_q && s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	// write address decode
	always_comb
	begin
		unique case ({awAddr_q[7:2], 2'b00})
			tcpwm_pkg::OFS_CTRL,   tcpwm_pkg::OFS_OUTCFG,
			tcpwm_pkg::OFS_PERIOD, tcpwm_pkg::OFS_CHB,
			tcpwm_pkg::OFS_CHC,    tcpwm_pkg::OFS_CHD,
			tcpwm_pkg::OFS_COUNT,  tcpwm_pkg::OFS_STATUS,
			tcpwm_pkg::OFS_MASK:
				wrHit = 1'b1;
			default:
				wrHit = 1'b0;
		endcase
	end

	// read mux, narrow fields zero extended
	always_comb
	begin
		rdMux = 32'h0000_0000;
		rdHit = 1'b1;
		unique case ({s_axi_araddr[7:2], 2'b00})
			tcpwm_pkg::OFS_CTRL:   rdMux[5:0] = ctrl_q;
			tcpwm_pkg::OFS_OUTCFG: rdMux[5:0] = outCfg_q;
			tcpwm_pkg::OFS_PERIOD: rdMux[COUNT_W-1:0] = period_compare_reg_q;
			tcpwm_pkg::OFS_CHB:    rdMux[COUNT_W-1:0] = change_point_b_reg_q;
			tcpwm_pkg::OFS_CHC:    rdMux[COUNT_W-1:0] = change_point_c_reg_q;
			tcpwm_pkg::OFS_CHD:    rdMux[COUNT_W-1:0] = change_point_d_reg_q;
			tcpwm_pkg::OFS_COUNT:  rdMux[COUNT_W-1:0] = channel_counter_q;
			tcpwm_pkg::OFS_STATUS: rdMux[3:0] = status_q;
			tcpwm_pkg::OFS_MASK:   rdMux[3:0] = mask_q;
			default:               rdHit = 1'b0;
		endcase
	end

	// read response; reads have no side effects
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rvalid_q <= 1'b0;
			rresp_q  <= tcpwm_pkg::RESP_OKAY;
			rdata_q  <= 32'h0000_0000;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rresp_q  <= rdHit ? tcpwm_pkg::RESP_OKAY
				: tcpwm_pkg::RESP_SLVERR;
			rdata_q  <= rdMux;
		end
		else if (rvalid_q && s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// ************************************************************
	// configuration registers
	// ************************************************************
	// compare values change immediately; software should stop first
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl_q               <= tcpwm_pkg::RST_CTRL;
			outCfg_q             <= tcpwm_pkg::RST_OUTCFG;
			period_compare_reg_q <= COUNT_W'(tcpwm_pkg::RST_PERIOD);
			change_point_b_reg_q <= COUNT_W'(tcpwm_pkg::RST_CHANGE);
			change_point_c_reg_q <= COUNT_W'(tcpwm_pkg::RST_CHANGE);
			change_point_d_reg_q <= COUNT_W'(tcpwm_pkg::RST_CHANGE);
			mask_q               <= tcpwm_pkg::RST_EVT;
		end
		else if (doWrite)
		begin
			unique case ({awAddr_q[7:2], 2'b00})
				tcpwm_pkg::OFS_CTRL:
					ctrl_q <= 6'(tcpwm_pkg::applyStrb(32'(ctrl_q),
						wData_q, wStrb_q));
				tcpwm_pkg::OFS_OUTCFG:
					outCfg_q <= 6'(tcpwm_pkg::applyStrb(32'(outCfg_q),
						wData_q, wStrb_q));
				tcpwm_pkg::OFS_PERIOD:
					period_compare_reg_q <= COUNT_W'(tcpwm_pkg::applyStrb(
						32'(period_compare_reg_q), wData_q, wStrb_q));
				tcpwm_pkg::OFS_CHB:
					change_point_b_reg_q <= COUNT_W'(tcpwm_pkg::applyStrb(
						32'(change_point_b_reg_q), wData_q, wStrb_q));
				tcpwm_pkg::OFS_CHC:
					change_point_c_reg_q <= COUNT_W'(tcpwm_pkg::applyStrb(
						32'(change_point_c_reg_q), wData_q, wStrb_q));
				tcpwm_pkg::OFS_CHD:
					change_point_d_reg_q <= COUNT_W'(tcpwm_pkg::applyStrb(
						32'(change_point_d_reg_q), wData_q, wStrb_q));
				tcpwm_pkg::OFS_MASK:
					mask_q <= 4'(tcpwm_pkg::applyStrb(32'(mask_q),
						wData_q, wStrb_q));
				default:
					;                                // held elsewhere or unmapped
			endcase
		end
	end

	// ************************************************************
	// count source
	// ************************************************************
	// divider terminal mask per source code
	always_comb
	begin
		unique case (ctrl_q.srcSel)
			tcpwm_pkg::SRC_DIV1: divMask = 3'h0;
			tcpwm_pkg::SRC_DIV2: divMask = 3'h1;
			tcpwm_pkg::SRC_DIV4: divMask = 3'h3;
			tcpwm_pkg::SRC_DIV8: divMask = 3'h7;
		endcase
	end

	// free divider, restarts whenever the timer is stopped
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			prescale_q <= 3'h0;
		else if (!ctrl_q.run)
			prescale_q <= 3'h0;
		else
			prescale_q <= prescale_q + 3'h1;
	end

	// undivided source ticks every clock while running
	assign tick = ctrl_q.run && ((prescale_q & divMask) == divMask);

	// ************************************************************
	// channel counter
	// ************************************************************
	assign periodHit = tick && (channel_counter_q == period_compare_reg_q);

	// clears straight to zero so the next tick counts 1, no gap
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			channel_counter_q <= '0;
		else if (doWrite && ({awAddr_q[7:2], 2'b00} == tcpwm_pkg::OFS_COUNT))
			channel_counter_q <= COUNT_W'(tcpwm_pkg::applyStrb(
				32'(channel_counter_q), wData_q, wStrb_q));
		else if (periodHit && ctrl_q.clearOnPeriod)
			channel_counter_q <= '0;
		else if (tick)
			channel_counter_q <= channel_counter_q + COUNT_W'(1);
	end

	// ************************************************************
	// output channels
	// ************************************************************
	// cutoff only acts when software enables it
	assign forceOff = ctrl_q.cutoffEn && cutoffIn;

	for (genvar i = 0; i < 3; i++)
	begin : gChan
		logic [COUNT_W-1:0] cmp;
		assign cmp = (i == 0) ? change_point_b_reg_q
			: (i == 1) ? change_point_c_reg_q
			: change_point_d_reg_q;
		tcpwm_chan #(
			.COUNT_W     (COUNT_W)
		) uChan (
			.clk         (clk),
			.reset_n     (reset_n),
			.run         (ctrl_q.run),
			.tick        (tick),
			.count       (channel_counter_q),
			.periodHit   (periodHit),
			.forceOff    (forceOff),
			.changePoint (cmp),
			.activeHigh  (outCfg_q.activeHigh[i]),
			.initLevel   (outCfg_q.initLevel[i]),
			.hit         (chanHit[i]),
			.level_q     (chanLevel[i])
		);
	end

	assign pwm_out_b = chanLevel[0];
	assign pwm_out_c = chanLevel[1];
	assign pwm_out_d = chanLevel[2];

	// ************************************************************
	// events and interrupt
	// ************************************************************
	assign events = {chanHit[2], chanHit[1], chanHit[0], periodHit};

	// write one to clear; a new event in the same cycle wins
	always_comb
	begin
		status_d = status_q;
		if (doWrite && ({awAddr_q[7:2], 2'b00} == tcpwm_pkg::OFS_STATUS)
			&& wStrb_q[0])
			status_d = status_q & ~wData_q[3:0];
		status_d = status_d | events;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			status_q <= tcpwm_pkg::RST_EVT;
		else
			status_q <= status_d;
	end

	// level interrupt while any enabled event is pending
	assign irq = |(status_q & mask_q);

	// converter trigger pulse, one clock per period match
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			adTrigger_q <= 1'b0;
		else
			adTrigger_q <= periodHit && ctrl_q.adTrigEn;
	end

endmodule // tcpwm_timer

`default_nettype wire

//--- tcpwm_checker.sv
// checker of the pwm timer: bus handshakes, pin levels, irq
// assumes bound to tcpwm_timer; config shadowed from bus writes
`default_nettype none

module tcpwm_checker (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset_n,
	// axi4-lite write side
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// axi4-lite read side
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// pins
	input wire logic        cutoffIn,
	input wire logic        pwm_out_b,
	input wire logic        pwm_out_c,
	input wire logic        pwm_out_d,
	input wire logic        irq,
	input wire logic        adTrigger_q
);
	logic [7:0]  wAddr_q;  // last taken write address
	logic [31:0] wData_q;  // last taken write data
	logic [2:0]  actHi_q;  // shadow of polarity
	logic        cutEn_q;  // shadow of cutoff enable
	logic        mask0_q;  // shadow of period mask
	logic [2:0]  pins;     // d, c, b

	assign pins = {pwm_out_d, pwm_out_c, pwm_out_b};

	// shadow lags a cycle; config never changes mid event
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wAddr_q <= 8'h00;
			wData_q <= 32'h0;
			actHi_q <= 3'h7;
			cutEn_q <= 1'b0;
			mask0_q <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
				wAddr_q <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready)
				wData_q <= s_axi_wdata;
			if ($rose(s_axi_bvalid) && s_axi_bresp == tcpwm_pkg::RESP_OKAY)
			begin
				if (wAddr_q[7:2] == tcpwm_pkg::OFS_OUTCFG[7:2])
					actHi_q <= wData_q[2:0];
				if (wAddr_q[7:2] == tcpwm_pkg::OFS_CTRL[7:2])
					cutEn_q <= wData_q[4];
				if (wAddr_q[7:2] == tcpwm_pkg::OFS_MASK[7:2])
					mask0_q <= wData_q[0];
			end
		end
	end

	// ************************************************************
	// properties
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready high while rvalid");
	a_ar_to_r: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_r_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_w_to_b: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	a_irq_fall: assert property ($fell(irq) |-> s_axi_bvalid)
		else $error("irq fell without write");
	a_period_irq: assert property (adTrigger_q && mask0_q |-> irq)
		else $error("irq missing on period");
	a_trig_inactive: assert property (adTrigger_q |-> pins == ~actHi_q)
		else $error("pins active after period");
	a_cut_inactive: assert property (cutoffIn && cutEn_q |=> pins == ~actHi_q)
		else $error("pins active in cutoff");

	c_trig: cover property (adTrigger_q);
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == tcpwm_pkg::RESP_SLVERR);
	c_irq_fall: cover property ($fell(irq));

endmodule // tcpwm_checker

bind tcpwm_timer tcpwm_checker u_chk (
	.clk(clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.cutoffIn(cutoffIn), .pwm_out_b(pwm_out_b), .pwm_out_c(pwm_out_c),
	.pwm_out_d(pwm_out_d), .irq(irq), .adTrigger_q(adTrigger_q));

`default_nettype wire

//--- tcpwm_load.sv
// behavioural load on one pwm pin: measures level run lengths
// assumes pin changes after rising edges
`default_nettype none

module tcpwm_load (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// observed pin
	input  wire logic        pin,
	// last complete low and high runs, in cycles
	output logic [15:0]      lowLen,
	output logic [15:0]      highLen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        prev_q;                        // level last cycle
	logic [15:0] run_q;                         // cycles at this level

	// latch finished run on a flip
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			prev_q <= 1'b0;
			run_q <= 16'h0;
			lowLen <= 16'h0;
			highLen <= 16'h0;
		end
		else if (pin !== prev_q)
		begin
			if (prev_q)
				highLen <= run_q;
			else
				lowLen <= run_q;
			prev_q <= pin;
			run_q <= 16'h1;
		end
		else
			run_q <= run_q + 16'h1;
	end
endmodule // tcpwm_load

`default_nettype wire

//--- test_three_channel_pwm_timer.sv
// self-checking bench of the pwm timer over axi4-lite
// assumes 25 MHz clock; pin loads measure runs
`default_nettype none

module test_three_channel_pwm_timer;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  awAddr = 8'h00, arAddr = 8'h00;
	logic [31:0] wData = 32'h0, rData;
	logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
	logic        arValid = 1'b0, rReady = 1'b0, cutoffIn = 1'b0;
	logic        awReady, wReady, bValid, arReady, rValid;
	logic [1:0]  bResp, rResp, rs;
	logic [31:0] rv;  // last read word
	logic        pwmB, pwmC, pwmD, irq, adTrig;
	wire logic [15:0] lo [3];                   // low runs b, c, d
	wire logic [15:0] hi [3];                   // high runs b, c, d
	int          n_fail = 0, checks_done = 0, cyc = 0;

`define CHK(nm, ex, got) \
	begin \
		checks_done++; \
		if ((got) !== (ex)) \
		begin \
			$display("MISMATCH %s exp %h got %h", nm, ex, got); \
			n_fail++; \
		end \
	end

	always #20 clk = ~clk;

	tcpwm_timer #(.COUNT_W(16)) DUT (
		.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awAddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.cutoffIn(cutoffIn), .pwm_out_b(pwmB), .pwm_out_c(pwmC),
		.pwm_out_d(pwmD), .irq(irq), .adTrigger_q(adTrig));
	tcpwm_load LB (.clk(clk), .reset_n(reset_n), .pin(pwmB),
		.lowLen(lo[0]), .highLen(hi[0]));
	tcpwm_load LC (.clk(clk), .reset_n(reset_n), .pin(pwmC),
		.lowLen(lo[1]), .highLen(hi[1]));
	tcpwm_load LD (.clk(clk), .reset_n(reset_n), .pin(pwmD),
		.lowLen(lo[2]), .highLen(hi[2]));

	// ************************************************************
	// bus tasks
	// ************************************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit ad = 0, wd = 0, ra, rw;
		@(posedge clk);
		awAddr <= a; wData <= d;
		awValid <= 1'b1; wValid <= 1'b1; bReady <= 1'b1;
		while (!(ad && wd))
		begin
			@(negedge clk); ra = awReady; rw = wReady;
			@(posedge clk);
			if (ra) begin ad = 1; awValid <= 1'b0; end
			if (rw) begin wd = 1; wValid <= 1'b0; end
		end
		do @(negedge clk); while (bValid !== 1'b1);
		rs = bResp;
		@(posedge clk) bReady <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		arAddr <= a; arValid <= 1'b1; rReady <= 1'b1;
		do @(negedge clk); while (arReady !== 1'b1);
		@(posedge clk) arValid <= 1'b0;
		do @(negedge clk); while (rValid !== 1'b1);
		rv = rData; rs = rResp;
		@(posedge clk) rReady <= 1'b0;
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_regs();
		rd(tcpwm_pkg::OFS_CTRL); `CHK("ctrl", 32'(tcpwm_pkg::RST_CTRL), rv)
		rd(tcpwm_pkg::OFS_OUTCFG); `CHK("outcfg", 32'h7, rv)
		rd(tcpwm_pkg::OFS_PERIOD); `CHK("period", 32'hffff, rv)
		rd(tcpwm_pkg::OFS_MASK); `CHK("mask", 32'h0, rv)
		rd(8'h24); `CHK("hole data", 32'h0, rv)
		`CHK("hole rresp", tcpwm_pkg::RESP_SLVERR, rs)
		wr(8'h24, 32'h1); `CHK("hole bresp", tcpwm_pkg::RESP_SLVERR, rs)
	endtask

	// period 8, change points 1, 3, 5
	task automatic t_pwm();
		wr(tcpwm_pkg::OFS_PERIOD, 32'h7); wr(tcpwm_pkg::OFS_CHB, 32'h1);
		wr(tcpwm_pkg::OFS_CHC, 32'h3); wr(tcpwm_pkg::OFS_CHD, 32'h5);
		wr(tcpwm_pkg::OFS_MASK, 32'h1); wr(tcpwm_pkg::OFS_CTRL, 32'h3);
		repeat (40) @(posedge clk);
		for (int i = 0; i < 3; i++)
		begin
			`CHK("low run", 16'(2 * i + 2), lo[i])
			`CHK("high run", 16'(6 - 2 * i), hi[i])
		end
		`CHK("irq", 1'b1, irq)
		rd(tcpwm_pkg::OFS_STATUS); `CHK("period evt", 1'b1, rv[0])
		rd(tcpwm_pkg::OFS_COUNT); `CHK("count cleared", 1'b1, rv <= 7)
		wr(tcpwm_pkg::OFS_MASK, 32'h0); wr(tcpwm_pkg::OFS_STATUS, 32'hf);
		`CHK("irq masked", 1'b0, irq)
	endtask

	// halved count source doubles every run
	task automatic t_div();
		wr(tcpwm_pkg::OFS_CTRL, 32'h3 | (32'(tcpwm_pkg::SRC_DIV2) << 2));
		repeat (60) @(posedge clk);
		`CHK("div low", 16'h4, lo[0])
		`CHK("div high", 16'hc, hi[0])
	endtask

	// active low, then initial levels while stopped
	task automatic t_pol();
		wr(tcpwm_pkg::OFS_CTRL, 32'h3); wr(tcpwm_pkg::OFS_OUTCFG, 32'h0);
		repeat (40) @(posedge clk);
		`CHK("inv high", 16'h2, hi[0])
		`CHK("inv low", 16'h6, lo[0])
		wr(tcpwm_pkg::OFS_CTRL, 32'h2); wr(tcpwm_pkg::OFS_OUTCFG, 32'h28);
		repeat (2) @(posedge clk);
		`CHK("init level", 3'b101, {pwmD, pwmC, pwmB})
	endtask

	// cutoff holds pins low only when enabled
	task automatic t_cut();
		wr(tcpwm_pkg::OFS_OUTCFG, 32'h7); wr(tcpwm_pkg::OFS_CTRL, 32'h13);
		@(posedge clk); cutoffIn <= 1'b1;
		repeat (12) @(posedge clk);
		repeat (8)
		begin
			@(posedge clk);
			`CHK("cutoff pins", 3'b000, {pwmD, pwmC, pwmB})
		end
		cutoffIn <= 1'b0;
		wr(tcpwm_pkg::OFS_CTRL, 32'h3);
		@(posedge clk); cutoffIn <= 1'b1;
		repeat (40) @(posedge clk);
		`CHK("no cutoff low", 16'h2, lo[0])
		`CHK("no cutoff high", 16'h6, hi[0])
		cutoffIn <= 1'b0;
	endtask

	// one converter trigger per period
	task automatic t_trig();
		int n = 0;
		wr(tcpwm_pkg::OFS_MASK, 32'h1); wr(tcpwm_pkg::OFS_CTRL, 32'h23);
		repeat (8) @(posedge clk);
		repeat (32)
		begin
			@(posedge clk);
			if (adTrig === 1'b1) n++;
		end
		`CHK("trig pulses", 4, n)
	endtask

	task automatic end_of_test();
		if (n_fail == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// hang guard, run needs under 1000 cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			n_fail++;
			end_of_test();
		end
	end

	initial
	begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		t_regs();
		t_pwm();
		t_div();
		t_pol();
		t_cut();
		t_trig();
		end_of_test();
	end
`undef CHK
endmodule // test_three_channel_pwm_timer

`default_nettype wire
